// >>> rtl/serial_bus_link_consts.svh
`ifndef SERIAL_BUS_LINK_CONSTS_SVH
`define SERIAL_BUS_LINK_CONSTS_SVH
// Function
// - cycle timer at 14h resets zero: seconds 0-6, cycle 7-19, offset 20-31
// - timer advances or takes a received load only per cycle master, source and enable settings; host writes always load
// - channel select register at 18h resets zero, bits 16-31 reserved
// - port enable a set: accept iso packets matching channel field a, bits 2-7
// - port enable b set: accept iso packets matching channel field b, bits 10-15
// - diagnostic at 20h: unlock and snoop always writable, others only when unlocked
// - ram test: each access at 80h reaches next ram word from word 00h
// - snoop bit set: receiver accepts every packet in snoop format
// - busy phase bit picks ack_busyB when set, ack_busyA when clear
// - diagnostic bit 2 set after arbitration reset gap idle time
// - diagnostic bit 3 set after subaction gap idle time
// - address clear bit clears ram address counter and control mismatch flag
// - ram test write stores diagnostic bit 6 into ram bit 33
// - ram test read sets bit 7 when stored control bit differs from bit 6
// - ram test active only while test bit and unlock bit both set
// - phy access at 24h resets zero: lower half requests, upper half replies
// - read request bit sends phy read, cleared once the request leaves
// - write request bit sends phy write, cleared once the request leaves
// - request address bits 4-7, write data bits 8-15, 2-3 and 16-19 reserved
// - phy reply address lands in bits 20-23, reply data in 24-31
// - every phy reply raises the reply event flag

// register byte offsets on the host port
`define OFF_CYCLE_TIMER 8'h14
`define OFF_RX_CHAN_SEL 8'h18
`define OFF_DIAG 8'h20
`define OFF_PHY_ACCESS 8'h24
`define OFF_RAM_TEST 8'h80
`define RESET_WORD 32'h0000_0000
// cycle timer fields and wrap points
`define CT_SEC_LSB 0
`define CT_SEC_MSB 6
`define CT_CYC_LSB 7
`define CT_CYC_MSB 19
`define CT_OFS_LSB 20
`define CT_OFS_MSB 31
`define CT_OFS_LAST 12'hbff
`define CT_CYC_LAST 13'h1f3f
// channel select fields, tag bits sit below each channel
`define CH_A_LSB 2
`define CH_A_MSB 7
`define CH_B_LSB 10
`define CH_B_MSB 15
`define CH_MASK 32'h0000_ffff
// diagnostic bits
`define DG_SNOOP 0
`define DG_BUSY 1
`define DG_ARB_GAP 2
`define DG_FAIR_GAP 3
`define DG_UNLOCK 4
`define DG_ADR_CLR 5
`define DG_TAG 6
`define DG_TAG_ERR 7
`define DG_RAM_TEST 8
`define DG_LOCKED_MASK 32'h0000_01ce
// phy access fields
`define PA_RD 0
`define PA_WR 1
`define PA_RQ_AD_LSB 4
`define PA_RQ_AD_MSB 7
`define PA_RQ_DT_LSB 8
`define PA_RQ_DT_MSB 15
`define PA_RX_AD_LSB 20
`define PA_RX_AD_MSB 23
`define PA_RX_DT_LSB 24
`define PA_RX_DT_MSB 31
`define PA_MASK 32'hfff0_fff3
// ram word control bit
`define RAM_CTRL_BIT 33
`endif

// >>> rtl/serial_bus_link_pkg.sv
package serial_bus_link_pkg;
  // which register a host access targets
  typedef enum logic [2:0] {SEL_NONE, SEL_CT, SEL_CH, SEL_DG, SEL_PA, SEL_RAM} reg_sel_t;
  // isochronous channel number
  typedef logic [5:0] iso_channel_t;
endpackage : serial_bus_link_pkg

// >>> rtl/cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_link_consts.svh"
module cycle_timer import serial_bus_link_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host load
  input wire logic load_en,
  input wire logic [31:0] load_value,
  // control settings
  input wire logic cycle_master,
  input wire logic cycle_source,
  input wire logic timer_enable,
  // timing events
  input wire logic offset_tick,
  input wire logic cycle_in,
  input wire logic cs_load,
  input wire logic [31:0] cs_value,
  // timer value
  output logic [31:0] value_q
);
  logic [6:0] sec;
  logic [12:0] cyc;
  logic [11:0] ofs;
  logic roll;
  logic [31:0] value_d;

  // field views
  assign sec = value_q[`CT_SEC_MSB:`CT_SEC_LSB];
  assign cyc = value_q[`CT_CYC_MSB:`CT_CYC_LSB];
  assign ofs = value_q[`CT_OFS_MSB:`CT_OFS_LSB];

  // next count; external cycle source overrides the offset wrap
  always_comb begin
    value_d = value_q;
    if (cycle_source) begin
      roll = cycle_in;
    end else begin
      roll = offset_tick && (ofs == `CT_OFS_LAST);
    end
    if (roll) begin
      value_d[`CT_OFS_MSB:`CT_OFS_LSB] = '0;
      if (cyc == `CT_CYC_LAST) begin
        value_d[`CT_CYC_MSB:`CT_CYC_LSB] = '0;
        value_d[`CT_SEC_MSB:`CT_SEC_LSB] = sec + 7'h01; // wraps at 128
      end else begin
        value_d[`CT_CYC_MSB:`CT_CYC_LSB] = cyc + 13'h0001;
      end
    end else if (offset_tick && (ofs != `CT_OFS_LAST)) begin
      value_d[`CT_OFS_MSB:`CT_OFS_LSB] = ofs + 12'h001;
    end
  end

  // host load wins; a non-master follows the received cycle start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      value_q <= `RESET_WORD;
    end else if (load_en) begin
      value_q <= load_value;
    end else if (cs_load && !cycle_master) begin
      value_q <= cs_value;
    end else if (timer_enable) begin
      value_q <= value_d;
    end
  end
endmodule : cycle_timer
`default_nettype wire

// >>> rtl/serial_bus_link_misc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_link_consts.svh"
module serial_bus_link_misc_regs import serial_bus_link_pkg::*; #(
  parameter int RAM_DEPTH = 512,
  parameter int RAM_W = 34
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host register port
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_ack,
  // cycle timer control from the control register
  input wire logic cycle_master,
  input wire logic cycle_source,
  input wire logic cycle_timer_enable,
  // cycle timer events
  input wire logic offset_tick,
  input wire logic cycle_in,
  input wire logic cs_load,
  input wire logic [31:0] cs_value,
  // receiver side
  input wire logic rx_channel_a_enable,
  input wire logic rx_channel_b_enable,
  input wire logic iso_valid,
  input wire logic [5:0] iso_channel,
  output logic iso_accept,
  output logic promiscuous_receive,
  output logic busy_ack_phase,
  // bus idle detectors
  input wire logic arb_gap_pulse,
  input wire logic fair_gap_pulse,
  // phy request
  output logic phy_req_valid,
  output logic phy_req_write,
  output logic [3:0] phy_req_addr,
  output logic [7:0] phy_req_data,
  input wire logic phy_req_ready,
  // phy reply
  input wire logic phy_rx_valid,
  input wire logic [3:0] phy_rx_addr,
  input wire logic [7:0] phy_rx_data,
  output logic phy_reply_event
);
  localparam int AW = $clog2(RAM_DEPTH);

  reg_sel_t sel;
  logic wr_en;
  logic rd_en;
  logic [31:0] ct_value;
  logic [31:0] chsel_q;
  logic [31:0] diag_q;
  logic [31:0] pa_q;
  logic [31:0] host_rdata_q;
  logic host_ack_q;
  logic phy_reply_event_q;
  logic test_mode;
  logic adr_clr;
  logic ram_wr;
  logic ram_rd;
  logic ram_mismatch;
  logic phy_fire;
  logic [AW-1:0] ram_addr_q;
  logic [RAM_W-1:0] ram_q [RAM_DEPTH];
  logic [RAM_W-1:0] ram_word;
  logic [RAM_W-1:0] ram_rword;
  iso_channel_t ch_a;
  iso_channel_t ch_b;

  // address decode; 80h only maps to the ram while ram test runs, else it reads zero
  always_comb begin
    case (host_addr)
      `OFF_CYCLE_TIMER: begin
        sel = SEL_CT;
      end
      `OFF_RX_CHAN_SEL: begin
        sel = SEL_CH;
      end
      `OFF_DIAG: begin
        sel = SEL_DG;
      end
      `OFF_PHY_ACCESS: begin
        sel = SEL_PA;
      end
      `OFF_RAM_TEST: begin
        sel = test_mode ? SEL_RAM : SEL_NONE;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
  end

  // a cycle with both strobes counts as a write
  assign wr_en = host_sel && host_wr;
  assign rd_en = host_sel && host_rd && !host_wr;

  // cycle timer proper lives in its own counter
  cycle_timer u_cycle_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load_en(wr_en && (sel == SEL_CT)),
    .load_value(host_wdata),
    .cycle_master(cycle_master),
    .cycle_source(cycle_source),
    .timer_enable(cycle_timer_enable),
    .offset_tick(offset_tick),
    .cycle_in(cycle_in),
    .cs_load(cs_load),
    .cs_value(cs_value),
    .value_q(ct_value)
  );

  // channel select; tag bits are stored but never compared
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chsel_q <= `RESET_WORD;
    end else if (wr_en && (sel == SEL_CH)) begin
      chsel_q <= host_wdata & `CH_MASK;
    end
  end

  assign ch_a = chsel_q[`CH_A_MSB:`CH_A_LSB];
  assign ch_b = chsel_q[`CH_B_MSB:`CH_B_LSB];

  // snoop overrides all filtering
  always_comb begin
    iso_accept = 1'b0;
    if (iso_valid) begin
      if (diag_q[`DG_SNOOP]) begin
        iso_accept = 1'b1;
      end else if (rx_channel_a_enable && (iso_channel == ch_a)) begin
        iso_accept = 1'b1;
      end else if (rx_channel_b_enable && (iso_channel == ch_b)) begin
        iso_accept = 1'b1;
      end
    end
  end

  assign promiscuous_receive = diag_q[`DG_SNOOP];
  assign busy_ack_phase = diag_q[`DG_BUSY];

  // ram test gating and strobes
  assign test_mode = diag_q[`DG_RAM_TEST] && diag_q[`DG_UNLOCK];
  assign adr_clr = wr_en && (sel == SEL_DG) && diag_q[`DG_UNLOCK] && host_wdata[`DG_ADR_CLR];
  assign ram_wr = wr_en && (sel == SEL_RAM);
  assign ram_rd = rd_en && (sel == SEL_RAM);
  assign ram_rword = ram_q[ram_addr_q];
  assign ram_mismatch = ram_rd && (ram_rword[`RAM_CTRL_BIT] != diag_q[`DG_TAG]);

  // diagnostic register; hardware sets are placed last so they win
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      diag_q <= `RESET_WORD;
    end else begin
      if (wr_en && (sel == SEL_DG)) begin
        diag_q[`DG_SNOOP] <= host_wdata[`DG_SNOOP];
        diag_q[`DG_UNLOCK] <= host_wdata[`DG_UNLOCK];
        if (diag_q[`DG_UNLOCK]) begin
          // locked bits follow the unlock state before this write
          diag_q[`DG_BUSY] <= host_wdata[`DG_BUSY];
          diag_q[`DG_ARB_GAP] <= host_wdata[`DG_ARB_GAP];
          diag_q[`DG_FAIR_GAP] <= host_wdata[`DG_FAIR_GAP];
          diag_q[`DG_TAG] <= host_wdata[`DG_TAG];
          diag_q[`DG_TAG_ERR] <= host_wdata[`DG_TAG_ERR];
          diag_q[`DG_RAM_TEST] <= host_wdata[`DG_RAM_TEST];
        end
      end
      if (adr_clr) begin
        diag_q[`DG_TAG_ERR] <= 1'b0;
      end
      if (ram_mismatch) begin
        diag_q[`DG_TAG_ERR] <= 1'b1;
      end
      if (arb_gap_pulse) begin
        diag_q[`DG_ARB_GAP] <= 1'b1;
      end
      if (fair_gap_pulse) begin
        diag_q[`DG_FAIR_GAP] <= 1'b1;
      end
    end
  end

  // ram word built with the test control bit in place
  always_comb begin
    ram_word = '0;
    ram_word[31:0] = host_wdata;
    ram_word[`RAM_CTRL_BIT] = diag_q[`DG_TAG];
  end

  // test memory has no reset, like the fifo storage it stands for
  always_ff @(posedge clk_sys) begin
    if (ram_wr) begin
      ram_q[ram_addr_q] <= ram_word;
    end
  end

  // address counter steps once per test access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ram_addr_q <= '0;
    end else if (adr_clr) begin
      ram_addr_q <= '0;
    end else if (ram_wr || ram_rd) begin
      ram_addr_q <= ram_addr_q + 1'b1;
    end
  end

  // phy access; a pending write goes before a pending read
  assign phy_req_valid = pa_q[`PA_RD] || pa_q[`PA_WR];
  assign phy_req_write = pa_q[`PA_WR];
  assign phy_req_addr = pa_q[`PA_RQ_AD_MSB:`PA_RQ_AD_LSB];
  assign phy_req_data = pa_q[`PA_RQ_DT_MSB:`PA_RQ_DT_LSB];
  assign phy_fire = phy_req_valid && phy_req_ready;

  // host write after the clear so a fresh request is not lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pa_q <= `RESET_WORD;
    end else begin
      if (phy_fire && pa_q[`PA_WR]) begin
        pa_q[`PA_WR] <= 1'b0;
      end else if (phy_fire) begin
        pa_q[`PA_RD] <= 1'b0;
      end
      if (wr_en && (sel == SEL_PA)) begin
        pa_q <= host_wdata & `PA_MASK;
      end
      if (phy_rx_valid) begin
        pa_q[`PA_RX_AD_MSB:`PA_RX_AD_LSB] <= phy_rx_addr;
        pa_q[`PA_RX_DT_MSB:`PA_RX_DT_LSB] <= phy_rx_data;
      end
    end
  end

  // reply event pulse for the interrupt register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phy_reply_event_q <= 1'b0;
    end else begin
      phy_reply_event_q <= phy_rx_valid;
    end
  end

  assign phy_reply_event = phy_reply_event_q;

  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_rdata_q <= `RESET_WORD;
    end else if (rd_en) begin
      case (sel)
        SEL_CT: begin
          host_rdata_q <= ct_value;
        end
        SEL_CH: begin
          host_rdata_q <= chsel_q;
        end
        SEL_DG: begin
          host_rdata_q <= diag_q;
        end
        SEL_PA: begin
          host_rdata_q <= pa_q;
        end
        SEL_RAM: begin
          host_rdata_q <= ram_rword[31:0];
        end
        default: begin
          host_rdata_q <= `RESET_WORD;
        end
      endcase
    end
  end

  // one ack per access, one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_ack_q <= 1'b0;
    end else begin
      host_ack_q <= wr_en || rd_en;
    end
  end

  assign host_rdata = host_rdata_q;
  assign host_ack = host_ack_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_ct_load;
    wr_en && (sel == SEL_CT) |=> ct_value == $past(host_wdata);
  endproperty
  a_ct_load: assert property (p_ct_load) else $error("cycle timer load lost");

  property p_ct_hold;
    !cycle_timer_enable && !(wr_en && (sel == SEL_CT)) && !cs_load |=> $stable(ct_value);
  endproperty
  a_ct_hold: assert property (p_ct_hold) else $error("cycle timer moved while off");

  property p_ch_rsv;
    wr_en && (sel == SEL_CH) |=> chsel_q[31:16] == 16'h0000 && chsel_q[15:0] == $past(host_wdata[15:0]);
  endproperty
  a_ch_rsv: assert property (p_ch_rsv) else $error("channel select write wrong");

  property p_match_a;
    iso_valid && rx_channel_a_enable && (iso_channel == chsel_q[7:2]) |-> iso_accept;
  endproperty
  a_match_a: assert property (p_match_a) else $error("port a packet refused");

  property p_match_b;
    iso_valid && rx_channel_b_enable && (iso_channel == chsel_q[15:10]) |-> iso_accept;
  endproperty
  a_match_b: assert property (p_match_b) else $error("port b packet refused");

  property p_locked;
    wr_en && (sel == SEL_DG) && !diag_q[`DG_UNLOCK] |=> $stable(diag_q[`DG_RAM_TEST]);
  endproperty
  a_locked: assert property (p_locked) else $error("locked bit changed");

  property p_ram_step;
    (ram_wr || ram_rd) && !adr_clr |=> ram_addr_q == $past(ram_addr_q) + 1'b1;
  endproperty
  a_ram_step: assert property (p_ram_step) else $error("ram counter did not step");

  property p_snoop;
    iso_valid && promiscuous_receive |-> iso_accept;
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop packet refused");

  property p_gaps;
    (arb_gap_pulse |=> diag_q[`DG_ARB_GAP]) and (fair_gap_pulse |=> diag_q[`DG_FAIR_GAP]);
  endproperty
  a_gaps: assert property (p_gaps) else $error("gap flag lost");

  property p_adr_clr;
    adr_clr |=> ram_addr_q == '0 && !diag_q[`DG_TAG_ERR];
  endproperty
  a_adr_clr: assert property (p_adr_clr) else $error("address clear failed");

  property p_mismatch;
    ram_rd && (ram_rword[`RAM_CTRL_BIT] != diag_q[`DG_TAG]) |=> diag_q[`DG_TAG_ERR];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

  property p_no_test;
    host_sel && (host_addr == `OFF_RAM_TEST) && !test_mode |=> $stable(ram_addr_q);
  endproperty
  a_no_test: assert property (p_no_test) else $error("ram reached outside test");

  property p_rd_sent;
    phy_fire && !phy_req_write && !(wr_en && (sel == SEL_PA)) |=> !pa_q[`PA_RD];
  endproperty
  a_rd_sent: assert property (p_rd_sent) else $error("read request not cleared");

  property p_reply;
    phy_rx_valid |=> phy_reply_event && pa_q[23:20] == $past(phy_rx_addr) && pa_q[31:24] == $past(phy_rx_data);
  endproperty
  a_reply: assert property (p_reply) else $error("phy reply not captured");

  c_phy_write: cover property (phy_fire && phy_req_write);
  c_reply: cover property (phy_rx_valid);
  c_ram_read: cover property (ram_rd);
  c_iso_a: cover property (iso_accept && rx_channel_a_enable);
endmodule : serial_bus_link_misc_regs
`default_nettype wire

// >>> testbench/phy_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module phy_link_model (
  // clock, reset and stall select
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  // request side
  input wire logic phy_req_valid,
  input wire logic phy_req_write,
  input wire logic [3:0] phy_req_addr,
  input wire logic [7:0] phy_req_data,
  output logic phy_req_ready,
  // reply side
  output logic phy_rx_valid,
  output logic [3:0] phy_rx_addr,
  output logic [7:0] phy_rx_data,
  // last request taken, for the bench
  output logic last_write,
  output logic [3:0] last_addr,
  output logic [7:0] last_data
);
  logic [7:0] regs_q [16];
  logic [2:0] wait_q;
  logic pend_q;
  // accept after a short or long stall, answer a read one cycle after taking it
  always_ff @(posedge clk_sys) begin
    phy_rx_valid <= 1'b0;
    phy_rx_addr <= ~phy_rx_addr; // idle reply lines toggle, no stale value
    phy_rx_data <= ~phy_rx_data;
    if (!rst_n) begin
      phy_req_ready <= 1'b0;
      wait_q <= 3'h0;
      pend_q <= 1'b0;
      phy_rx_addr <= 4'h5;
      phy_rx_data <= 8'ha5;
      last_write <= 1'b0;
      last_addr <= 4'h0;
      last_data <= 8'h00;
      for (int i = 0; i < 16; i++) regs_q[i] <= 8'h3f;
    end else begin
      if (phy_req_valid && phy_req_ready) begin
        phy_req_ready <= 1'b0;
        wait_q <= 3'h0;
        last_write <= phy_req_write;
        last_addr <= phy_req_addr;
        last_data <= phy_req_data;
        if (phy_req_write) regs_q[phy_req_addr] <= phy_req_data;
        else pend_q <= 1'b1;
      end else if (phy_req_valid) begin
        wait_q <= wait_q + 3'h1;
        if (!slow || wait_q == 3'h4) phy_req_ready <= 1'b1;
      end
      if (pend_q) begin
        pend_q <= 1'b0;
        phy_rx_valid <= 1'b1;
        phy_rx_addr <= last_addr;
        phy_rx_data <= regs_q[last_addr];
      end
    end
  end
endmodule : phy_link_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_link_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module tb import serial_bus_link_pkg::*; ;
  logic clk_sys = 0, rst_n = 0, host_sel = 0, host_wr = 0, host_rd = 0;
  logic [7:0] host_addr = 0;
  logic [31:0] host_wdata = 0, cs_value = 0, host_rdata, rd, v;
  logic cycle_master = 0, cycle_source = 0, cycle_timer_enable = 0, offset_tick = 0;
  logic cycle_in = 0, cs_load = 0, rx_channel_a_enable = 0, rx_channel_b_enable = 0;
  logic iso_valid = 0, arb_gap_pulse = 0, fair_gap_pulse = 0, phy_slow = 0;
  logic [5:0] iso_channel = 0, ch;
  logic host_ack, iso_accept, promiscuous_receive, busy_ack_phase, phy_req_valid;
  logic phy_req_write, phy_req_ready, phy_rx_valid, phy_reply_event, last_write, ea, eb, iv;
  logic [3:0] phy_req_addr, phy_rx_addr, last_addr, a;
  logic [7:0] phy_req_data, phy_rx_data, last_data, d;
  logic [31:0] ram_w [4];
  int mismatches = 0, checks_done = 0;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  serial_bus_link_misc_regs serial_bus_link_misc_regs_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
    .cycle_master(cycle_master), .cycle_source(cycle_source),
    .cycle_timer_enable(cycle_timer_enable), .offset_tick(offset_tick), .cycle_in(cycle_in),
    .cs_load(cs_load), .cs_value(cs_value), .rx_channel_a_enable(rx_channel_a_enable),
    .rx_channel_b_enable(rx_channel_b_enable), .iso_valid(iso_valid),
    .iso_channel(iso_channel), .iso_accept(iso_accept),
    .promiscuous_receive(promiscuous_receive), .busy_ack_phase(busy_ack_phase),
    .arb_gap_pulse(arb_gap_pulse), .fair_gap_pulse(fair_gap_pulse),
    .phy_req_valid(phy_req_valid), .phy_req_write(phy_req_write),
    .phy_req_addr(phy_req_addr), .phy_req_data(phy_req_data), .phy_req_ready(phy_req_ready),
    .phy_rx_valid(phy_rx_valid), .phy_rx_addr(phy_rx_addr), .phy_rx_data(phy_rx_data),
    .phy_reply_event(phy_reply_event));
  phy_link_model phy_link_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .slow(phy_slow),
    .phy_req_valid(phy_req_valid), .phy_req_write(phy_req_write),
    .phy_req_addr(phy_req_addr), .phy_req_data(phy_req_data), .phy_req_ready(phy_req_ready),
    .phy_rx_valid(phy_rx_valid), .phy_rx_addr(phy_rx_addr), .phy_rx_data(phy_rx_data),
    .last_write(last_write), .last_addr(last_addr), .last_data(last_data));
  // expected channel filter outcome
  function automatic logic exp_acc(logic [5:0] c, logic [31:0] s, logic ae, logic be, logic vl);
    return vl & ((ae & (c == s[7:2])) | (be & (c == s[15:10])));
  endfunction : exp_acc
  // one host access; ack is checked just after the edge that takes the access
  task automatic host_xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    host_sel <= 1'b1;
    host_wr <= w;
    host_rd <= !w;
    host_addr <= ad;
    host_wdata <= wd;
    @(posedge clk_sys);
    host_sel <= 1'b0;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    #1;
    `CHK("host_ack", 1'b1, host_ack)
    rd = host_rdata;
  endtask : host_xfer
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    host_xfer(1'b1, ad, wd);
  endtask : wr
  task automatic chk_rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
    host_xfer(1'b0, ad, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd
  // offset tick held for n edges
  task automatic tick(input int n);
    @(posedge clk_sys);
    offset_tick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    offset_tick <= 1'b0;
  endtask : tick
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
  // main sequence
  initial begin
    void'($urandom(65));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk_rd("cycle_timer", `OFF_CYCLE_TIMER, `RESET_WORD);
    chk_rd("chan_sel", `OFF_RX_CHAN_SEL, `RESET_WORD);
    chk_rd("diag", `OFF_DIAG, `RESET_WORD);
    chk_rd("phy_access", `OFF_PHY_ACCESS, `RESET_WORD);
    chk_rd("ram_locked", `OFF_RAM_TEST, 32'h0);
    chk_rd("unmapped", 8'h40, 32'h0);
    v = $urandom();
    wr(`OFF_RX_CHAN_SEL, v);
    chk_rd("chan_sel", `OFF_RX_CHAN_SEL, v & `CH_MASK);
    // random channels, a third aimed at each port field
    for (int i = 0; i < 30; i++) begin
      ch = (i % 3 == 0) ? v[7:2] : (i % 3 == 1) ? v[15:10] : 6'($urandom());
      {ea, eb, iv} = 3'($urandom());
      @(posedge clk_sys);
      iso_channel <= ch;
      rx_channel_a_enable <= ea;
      rx_channel_b_enable <= eb;
      iso_valid <= iv;
      #1;
      `CHK("iso_accept", exp_acc(ch, v, ea, eb, iv), iso_accept)
    end
    wr(`OFF_DIAG, 32'h1cf);
    chk_rd("diag_locked", `OFF_DIAG, 32'h1);
    @(posedge clk_sys);
    {rx_channel_a_enable, rx_channel_b_enable, iso_valid} <= 3'b001;
    #1;
    `CHK("snoop_accept", 1'b1, iso_accept)
    `CHK("snoop_out", 1'b1, promiscuous_receive)
    wr(`OFF_DIAG, 32'h10);
    wr(`OFF_DIAG, 32'h12);
    chk_rd("diag_busy", `OFF_DIAG, 32'h12);
    `CHK("busy_phase", 1'b1, busy_ack_phase)
    wr(`OFF_DIAG, 32'h10);
    `CHK("busy_phase", 1'b0, busy_ack_phase)
    @(posedge clk_sys);
    arb_gap_pulse <= 1'b1;
    @(posedge clk_sys);
    arb_gap_pulse <= 1'b0;
    chk_rd("diag_arb", `OFF_DIAG, 32'h14);
    @(posedge clk_sys);
    fair_gap_pulse <= 1'b1;
    @(posedge clk_sys);
    fair_gap_pulse <= 1'b0;
    chk_rd("diag_fair", `OFF_DIAG, 32'h1c);
    wr(`OFF_DIAG, 32'hffff_fe30);
    chk_rd("diag_rsvd", `OFF_DIAG, 32'h10);
    // cycle timer: full wrap, steps, external boundary, hold, receive load
    wr(`OFF_CYCLE_TIMER, 32'hbfff_9fff);
    chk_rd("ct", `OFF_CYCLE_TIMER, 32'hbfff_9fff);
    @(posedge clk_sys);
    cycle_master <= 1'b1;
    cycle_timer_enable <= 1'b1;
    tick(1);
    chk_rd("ct_wrap", `OFF_CYCLE_TIMER, 32'h0);
    tick(3);
    chk_rd("ct_step", `OFF_CYCLE_TIMER, 32'h0030_0000);
    cycle_source <= 1'b1;
    cycle_in <= 1'b1;
    @(posedge clk_sys);
    cycle_in <= 1'b0;
    chk_rd("ct_cyc", `OFF_CYCLE_TIMER, 32'h0000_0080);
    cycle_timer_enable <= 1'b0;
    tick(2);
    chk_rd("ct_hold", `OFF_CYCLE_TIMER, 32'h0000_0080);
    v = $urandom();
    for (int i = 0; i < 2; i++) begin
      cycle_master <= 1'(i);
      cs_value <= v ^ {32{1'(i)}};
      cs_load <= 1'b1;
      @(posedge clk_sys);
      cs_load <= 1'b0;
      chk_rd("ct_load", `OFF_CYCLE_TIMER, v);
    end
    // phy writes then reads back, prompt and stalling partner
    for (int i = 0; i < 4; i++) begin
      {a, d} = 12'($urandom());
      phy_slow <= 1'(i);
      wr(`OFF_PHY_ACCESS, {16'h0, d, a, 4'h2});
      host_xfer(1'b0, `OFF_PHY_ACCESS, 0); // a fresh read, so rd never holds an old word
      for (int k = 0; k < 20 && rd[1:0] != 2'b00; k++) host_xfer(1'b0, `OFF_PHY_ACCESS, 0);
      `CHK("pa_wr_done", {16'h0, d, a, 4'h0}, rd)
      `CHK("phy_wr", {1'b1, a, d}, {last_write, last_addr, last_data})
      wr(`OFF_PHY_ACCESS, {16'h0, 8'h0, a, 4'h1});
      for (int k = 0; k < 20 && phy_reply_event !== 1'b1; k++) @(posedge clk_sys) #1;
      `CHK("reply_event", 1'b1, phy_reply_event)
      `CHK("phy_rd", {1'b0, a}, {last_write, last_addr})
      chk_rd("pa_reply", `OFF_PHY_ACCESS, {d, a, 12'h0, a, 4'h0});
    end
    // ram test: fill, read back, then tag mismatch and clear
    wr(`OFF_DIAG, 32'h10);
    wr(`OFF_DIAG, 32'h150);
    wr(`OFF_DIAG, 32'h170);
    chk_rd("diag_ram", `OFF_DIAG, 32'h150);
    for (int i = 0; i < 4; i++) begin
      ram_w[i] = $urandom();
      wr(`OFF_RAM_TEST, ram_w[i]);
    end
    wr(`OFF_DIAG, 32'h170);
    for (int i = 0; i < 4; i++) chk_rd("ram", `OFF_RAM_TEST, ram_w[i]);
    chk_rd("diag_tag_ok", `OFF_DIAG, 32'h150);
    wr(`OFF_DIAG, 32'h130);
    chk_rd("ram0", `OFF_RAM_TEST, ram_w[0]);
    chk_rd("diag_tag_err", `OFF_DIAG, 32'h190);
    wr(`OFF_DIAG, 32'h130);
    chk_rd("diag_clr", `OFF_DIAG, 32'h110);
    wr(`OFF_DIAG, 32'h100);
    chk_rd("diag_lock", `OFF_DIAG, 32'h100);
    chk_rd("ram_off", `OFF_RAM_TEST, 32'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
